// ### verilog/ius_params.svh
// constants of the channel-side status checker: status bit positions,
// register offsets, register fields and reset values.
// assumes a 32-bit apb slave port and an 8-bit status byte with odd parity.
`ifndef IUS_PARAMS_SVH
`define IUS_PARAMS_SVH

// status byte bit positions
`define IUS_B_ATT 3'h0
`define IUS_B_SM  3'h1
`define IUS_B_CUE 3'h2
`define IUS_B_BSY 3'h3
`define IUS_B_CE  3'h4
`define IUS_B_DE  3'h5
`define IUS_B_UC  3'h6
`define IUS_B_UE  3'h7

// register byte offsets
`define IUS_OFF_CTRL 8'h00
`define IUS_OFF_STAT 8'h04
`define IUS_OFF_CNT  8'h08

// control register fields
`define IUS_CF_DEV   0
`define IUS_CF_SEQ   8
`define IUS_CF_TIO   10
`define IUS_CF_CHAIN 11
`define IUS_CF_RETRY 12
`define IUS_CF_DYN   13
`define IUS_CF_CHK   14
`define IUS_CTRL_W   15
`define IUS_CTRL_RST 15'h4000

// status register fields
`define IUS_SF_INAPP 8
`define IUS_SF_SUPP  9
`define IUS_SF_PERR  10
`define IUS_SF_BUSY  11
`define IUS_SF_PST   12

`endif

// ### verilog/ius_pkg.sv
// types shared by the channel-side status checker
// assumes nothing beyond the params header for numbers
package ius_pkg;
    // sequence in which a status byte is presented
    typedef enum logic [1:0] {
        IUS_SEQ_SB  = 2'b00,  // short busy
        IUS_SEQ_IS  = 2'b01,  // initial selection by the channel
        IUS_SEQ_CUI = 2'b10,  // control-unit-initiated
        IUS_SEQ_RSV = 2'b11   // unused, judged like cu-initiated
    } ius_seq_e;
    // per-device history that picks the check set
    typedef enum logic [1:0] {
        IUS_PST_NONE = 2'b00,
        IUS_PST_ZERO = 2'b01, // zero initial status accepted
        IUS_PST_CE   = 2'b10  // ending with channel end only
    } ius_post_e;
    // status-in handshake states
    typedef enum logic [1:0] {
        IUS_HS_IDLE = 2'b00,
        IUS_HS_TAKE = 2'b01,
        IUS_HS_WAIT = 2'b10
    } ius_hs_e;
endpackage : ius_pkg

// ### verilog/ius_classify.sv
// combinational judge of one accepted status byte
// assumes the caller only uses the result for bytes with good parity
`timescale 1ns/100ps
`include "ius_params.svh"
module ius_classify (
    // byte and context
    input  wire logic [7:0]        st,
    input  wire ius_pkg::ius_seq_e seq,
    input  wire logic              tio,
    input  wire logic              chain,
    input  wire logic              retry,
    input  wire logic              dynrec,
    input  wire ius_pkg::ius_post_e post_st,
    // verdict
    output logic                   inapp,
    output logic                   cu_ok,
    output ius_pkg::ius_post_e     post_next
);
    logic att, sm, cue, bsy, ce, de, uc, ue;   // named status bits
    logic sel_bad, ch_bad, zero_bad, ce_bad;  // per check set
    logic cu_alone;                           // byte is cu end only
    assign att = st[`IUS_B_ATT];
    assign sm  = st[`IUS_B_SM];
    assign cue = st[`IUS_B_CUE];
    assign bsy = st[`IUS_B_BSY];
    assign ce  = st[`IUS_B_CE];
    assign de  = st[`IUS_B_DE];
    assign uc  = st[`IUS_B_UC];
    assign ue  = st[`IUS_B_UE];
    assign cu_alone = (st == 8'h04);

    // verdict per sequence and history
    always_comb
    begin
        sel_bad  = (de && !ce && !bsy)
                 || (st != 8'h00 && (st & 8'hF8) == 8'h00)
                 || (cue && !bsy && !ce && !de && (uc || ue));
        ch_bad   = (bsy && st != 8'h28 && st != 8'h09)
                 || (sm && (uc || ue) && (st & 8'h3D) == 8'h00);
        zero_bad = !ce || bsy;
        ce_bad   = bsy || ce || !(de || (cue && uc));
        // lone cu end waived: no chaining after a channel-end-only ending, or reconnection in cu sequence
        cu_ok    = cu_alone && ((!chain && post_st == ius_pkg::IUS_PST_CE)
                 || (dynrec && (seq == ius_pkg::IUS_SEQ_CUI
                                || seq == ius_pkg::IUS_SEQ_RSV)));
        inapp    = 1'b0;
        unique case (seq)
            ius_pkg::IUS_SEQ_SB:
                // only busy+sm, busy+sm+cue, busy alone pass
                inapp = !(st == 8'h0A || st == 8'h0E || st == 8'h08);
            ius_pkg::IUS_SEQ_IS:
                inapp = !tio && (sel_bad || (chain && ch_bad));
            default:
            begin
                // channel did not select: history decides
                if (post_st == ius_pkg::IUS_PST_ZERO)
                    inapp = zero_bad && !cu_ok;
                else if (post_st == ius_pkg::IUS_PST_CE)
                    inapp = ce_bad && !cu_ok;
            end
        endcase
    end

    // history after this byte
    always_comb
    begin
        if (cu_ok)
            post_next = post_st;
        else if (seq == ius_pkg::IUS_SEQ_IS && st == 8'h00)
            post_next = ius_pkg::IUS_PST_ZERO;
        else if ((st == 8'h10 && chain)
                 || (retry && chain && st == 8'h52)
                 || (ce && !de && !chain))
            post_next = ius_pkg::IUS_PST_CE;
        else
            post_next = ius_pkg::IUS_PST_NONE;
    end
endmodule : ius_classify

// ### verilog/ius_ptrack.sv
// per-device history store, one entry per device address
// assumes one write at most per cycle, read is combinational
`timescale 1ns/100ps
module ius_ptrack (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               arst_n,
    // access
    input  wire logic [7:0]         addr,
    input  wire logic               we,
    input  wire ius_pkg::ius_post_e wdata,
    output ius_pkg::ius_post_e      rdata
);
    ius_pkg::ius_post_e entry_reg  [256]; // history per device
    ius_pkg::ius_post_e entry_next [256];

    // one flop pair per device; flops rather than ram so reset clears all
    for (genvar i = 0; i < 256; i++)
    begin : g_ent
        always_comb
        begin
            entry_next[i] = entry_reg[i];
            if (we && addr == 8'(i))
                entry_next[i] = wdata;
        end
        always_ff @(posedge mclk or negedge arst_n)
        begin
            if (!arst_n)
                entry_reg[i] <= ius_pkg::IUS_PST_NONE;
            else
                entry_reg[i] <= entry_next[i];
        end
    end

    assign rdata = entry_reg[addr];
endmodule : ius_ptrack

// ### verilog/ius_chk.sv
// channel-side status checker: takes status bytes from the device pins,
// judges them, and reports over apb whether chaining must be suppressed.
// assumes an interlocked status-in / service-out handshake from the device
// and software that programs the operation context before each byte.
`timescale 1ns/100ps
`include "ius_params.svh"
module ius_chk (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // device pins
    input  wire logic [7:0]  bus_in,
    input  wire logic        bus_in_par,
    input  wire logic        status_in,
    output logic             service_out,
    // to channel logic
    output logic             chain_suppress,
    output logic             status_taken
);
    // pin synchronisers: first stage feeds only the second
    logic [9:0] pin_s1_reg;
    logic [9:0] pin_s2_reg;
    logic [7:0] st_s;            // synchronised status byte
    logic       par_s;           // synchronised parity
    logic       sin_s;           // synchronised status-in

    // handshake and capture state
    ius_pkg::ius_hs_e hs_reg, hs_next;
    logic        svc_reg, svc_next;       // service-out
    logic [7:0]  last_reg, last_next;     // last byte taken
    logic        supp_reg, supp_next;     // chaining suppressed
    logic        inapp_reg, inapp_next;   // sticky inappropriate
    logic        perr_reg, perr_next;     // sticky parity error
    logic [15:0] cnt_reg, cnt_next;       // bytes taken

    // software context
    logic [`IUS_CTRL_W-1:0] ctrl_reg, ctrl_next;
    logic [31:0] rd_reg, rd_next;         // apb read data

    // decoded context and verdict
    ius_pkg::ius_seq_e  seq;
    ius_pkg::ius_post_e post_rd;          // history of addressed device
    ius_pkg::ius_post_e post_wr;          // history after this byte
    logic        take;                    // byte judged this cycle
    logic        par_ok;                  // odd parity holds
    logic        inapp;                   // classifier verdict
    logic        cu_ok;                   // lone cu end waived
    logic        flag;                    // verdict counts as error
    logic        wr_acc;                  // apb write access
    logic        rd_setup;                // apb read setup
    logic        mapped;                  // offset exists

    assign seq     = ius_pkg::ius_seq_e'(ctrl_reg[`IUS_CF_SEQ +: 2]);
    assign st_s    = pin_s2_reg[7:0];
    assign par_s   = pin_s2_reg[8];
    assign sin_s   = pin_s2_reg[9];
    assign take    = (hs_reg == ius_pkg::IUS_HS_TAKE);
    assign par_ok  = ^{st_s, par_s};
    assign flag    = inapp && ctrl_reg[`IUS_CF_CHK];
    assign mapped  = (paddr == `IUS_OFF_CTRL) || (paddr == `IUS_OFF_STAT)
                   || (paddr == `IUS_OFF_CNT);
    assign wr_acc  = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;

    // double-flop the pins; bus is held by the device while status-in is up
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_s1_reg <= 10'h000;
            pin_s2_reg <= 10'h000;
        end
        else
        begin
            pin_s1_reg <= {status_in, bus_in_par, bus_in};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // judge of one byte
    ius_classify u_cls (
        .st        (st_s),
        .seq       (seq),
        .tio       (ctrl_reg[`IUS_CF_TIO]),
        .chain     (ctrl_reg[`IUS_CF_CHAIN]),
        .retry     (ctrl_reg[`IUS_CF_RETRY]),
        .dynrec    (ctrl_reg[`IUS_CF_DYN]),
        .post_st   (post_rd),
        .inapp     (inapp),
        .cu_ok     (cu_ok),
        .post_next (post_wr)
    );

    // history per device, written only for bytes with good parity
    ius_ptrack u_trk (
        .mclk   (mclk),
        .arst_n (arst_n),
        .addr   (ctrl_reg[`IUS_CF_DEV +: 8]),
        .we     (take && par_ok),
        .wdata  (post_wr),
        .rdata  (post_rd)
    );

    // a byte offered while busy waits: a rise of status-in is only acted on in idle
    // handshake: wait a cycle past status-in so the byte is settled
    always_comb
    begin
        hs_next   = hs_reg;
        svc_next  = svc_reg;
        last_next = last_reg;
        supp_next = supp_reg;
        cnt_next  = cnt_reg;
        unique case (hs_reg)
            ius_pkg::IUS_HS_IDLE:
                if (sin_s)
                    hs_next = ius_pkg::IUS_HS_TAKE;
            ius_pkg::IUS_HS_TAKE:
            begin
                hs_next   = ius_pkg::IUS_HS_WAIT;
                svc_next  = 1'b1;
                last_next = st_s;
                cnt_next  = cnt_reg + 16'h0001;
                // bad parity: byte not trusted, chaining stopped anyway
                if (!par_ok)
                    supp_next = 1'b1;
                else
                    supp_next = st_s[`IUS_B_UE]
                              || flag;
            end
            ius_pkg::IUS_HS_WAIT:
                if (!sin_s)
                begin
                    hs_next  = ius_pkg::IUS_HS_IDLE;
                    svc_next = 1'b0;
                end
            default:
            begin
                hs_next  = ius_pkg::IUS_HS_IDLE;
                svc_next = 1'b0;
            end
        endcase
    end

    // sticky flags: a set in the clearing cycle wins
    always_comb
    begin
        inapp_next = inapp_reg;
        perr_next  = perr_reg;
        if (wr_acc && paddr == `IUS_OFF_STAT)
        begin
            if (pwdata[`IUS_SF_INAPP])
                inapp_next = 1'b0;
            if (pwdata[`IUS_SF_PERR])
                perr_next = 1'b0;
        end
        if (take && par_ok && flag)
            inapp_next = 1'b1;
        if (take && !par_ok)
            perr_next = 1'b1;
    end

    // control writes and registered read data
    always_comb
    begin
        ctrl_next = ctrl_reg;
        rd_next   = rd_reg;
        if (wr_acc && paddr == `IUS_OFF_CTRL)
            ctrl_next = pwdata[`IUS_CTRL_W-1:0];
        if (rd_setup)
        begin
            rd_next = 32'h0000_0000;
            if (paddr == `IUS_OFF_CTRL)
                rd_next[`IUS_CTRL_W-1:0] = ctrl_reg;
            else if (paddr == `IUS_OFF_STAT)
            begin
                rd_next[7:0]           = last_reg;
                rd_next[`IUS_SF_INAPP] = inapp_reg;
                rd_next[`IUS_SF_SUPP]  = supp_reg;
                rd_next[`IUS_SF_PERR]  = perr_reg;
                rd_next[`IUS_SF_BUSY]  = (hs_reg != ius_pkg::IUS_HS_IDLE);
                rd_next[`IUS_SF_PST +: 2] = post_rd;
            end
            else if (paddr == `IUS_OFF_CNT)
                rd_next[15:0] = cnt_reg;
        end
    end

    // all state registers but the pin synchronisers
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hs_reg    <= ius_pkg::IUS_HS_IDLE;
            svc_reg   <= 1'b0;
            last_reg  <= 8'h00;
            supp_reg  <= 1'b0;
            cnt_reg   <= 16'h0000;
            inapp_reg <= 1'b0;
            perr_reg  <= 1'b0;
            ctrl_reg  <= `IUS_CTRL_RST;
            rd_reg    <= 32'h0000_0000;
        end
        else
        begin
            hs_reg    <= hs_next;
            svc_reg   <= svc_next;
            last_reg  <= last_next;
            supp_reg  <= supp_next;
            cnt_reg   <= cnt_next;
            inapp_reg <= inapp_next;
            perr_reg  <= perr_next;
            ctrl_reg  <= ctrl_next;
            rd_reg    <= rd_next;
        end
    end

    // outputs; zero-wait apb, error only for unmapped offsets
    assign prdata         = rd_reg;
    assign pready         = 1'b1;
    assign pslverr        = psel && penable && !mapped;
    assign service_out    = svc_reg;
    assign chain_suppress = supp_reg;
    assign status_taken   = take;

    // checks on the verdict
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    logic gp;  // good byte under judgement
    assign gp = take && par_ok;

    a_ue_suppress: assert property (gp && st_s[7] |=> chain_suppress)
        else $error("unit exception did not suppress chaining");
    a_inapp_sticky: assert property (gp && flag |=> supp_reg && inapp_reg)
        else $error("inappropriate byte not flagged");
    a_sb_pass: assert property (gp && seq == ius_pkg::IUS_SEQ_SB
        && st_s == 8'h0E |-> !inapp)
        else $error("legal short busy byte rejected");
    a_sb_reject: assert property (gp && seq == ius_pkg::IUS_SEQ_SB
        && !st_s[3] |-> inapp)
        else $error("short busy byte without busy passed");
    a_sel_de: assert property (gp && seq == ius_pkg::IUS_SEQ_IS
        && !ctrl_reg[`IUS_CF_TIO] && st_s == 8'h20 |-> inapp)
        else $error("lone device end at selection passed");
    a_sel_cue: assert property (gp && seq == ius_pkg::IUS_SEQ_IS
        && !ctrl_reg[`IUS_CF_TIO] && st_s == 8'h05 |-> inapp)
        else $error("cu end with attention at selection passed");
    a_sel_cuuc: assert property (gp && seq == ius_pkg::IUS_SEQ_IS
        && !ctrl_reg[`IUS_CF_TIO] && st_s == 8'h44 |-> inapp)
        else $error("cu end with unit check at selection passed");
    a_chain_busy: assert property (gp && seq == ius_pkg::IUS_SEQ_IS
        && !ctrl_reg[`IUS_CF_TIO] && ctrl_reg[`IUS_CF_CHAIN]
        && st_s == 8'h18 |-> inapp)
        else $error("busy at chained selection passed");
    a_post_ce: assert property (gp && seq != ius_pkg::IUS_SEQ_IS
        && post_rd == ius_pkg::IUS_PST_CE && st_s == 8'h30 |-> inapp)
        else $error("second channel end passed");
    a_cu_keep: assert property (gp && cu_ok |=> post_rd == $past(post_rd))
        else $error("waived cu end changed history");
    a_svc_drop: assert property (svc_reg && !sin_s |=> !service_out
        ##1 hs_reg == ius_pkg::IUS_HS_IDLE)
        else $error("service out held after status in fell");

    // helpers: good byte at a non test i/o selection, or judged by history
    logic sel_g;
    logic his_g;
    assign sel_g = gp && seq == ius_pkg::IUS_SEQ_IS && !ctrl_reg[`IUS_CF_TIO];
    assign his_g = gp && seq != ius_pkg::IUS_SEQ_IS && seq != ius_pkg::IUS_SEQ_SB;

    a_chain_pass: assert property (sel_g && ctrl_reg[`IUS_CF_CHAIN]
        && st_s == 8'h28 |-> !inapp)
        else $error("chained busy with device end rejected");
    a_chain_sm: assert property (sel_g && ctrl_reg[`IUS_CF_CHAIN]
        && st_s == 8'h42 |-> inapp)
        else $error("chained modifier with check passed");
    a_zero_arm: assert property (sel_g && st_s == 8'h00
        |=> post_rd == ius_pkg::IUS_PST_ZERO)
        else $error("zero status did not arm history");
    a_zero_busy: assert property (his_g && post_rd == ius_pkg::IUS_PST_ZERO
        && st_s == 8'h18 |-> inapp)
        else $error("busy after zero status passed");
    a_dyn_cue: assert property (his_g && ctrl_reg[`IUS_CF_DYN]
        && st_s == 8'h04 |-> !inapp)
        else $error("reconnection cu end rejected");
    a_ce_arm: assert property (his_g && ctrl_reg[`IUS_CF_CHAIN]
        && st_s == 8'h10 |=> post_rd == ius_pkg::IUS_PST_CE)
        else $error("lone channel end did not arm history");
    a_lone_cue: assert property (his_g && !ctrl_reg[`IUS_CF_CHAIN]
        && post_rd == ius_pkg::IUS_PST_CE && st_s == 8'h04 |-> !inapp)
        else $error("unchained lone cu end rejected");

    c_short_busy: cover property (gp && seq == ius_pkg::IUS_SEQ_SB);
    c_flagged:    cover property (gp && flag);
    c_cu_waived:  cover property (gp && cu_ok);
    c_zero_armed: cover property (gp && post_wr == ius_pkg::IUS_PST_ZERO);
    c_bad_parity: cover property (take && !par_ok);
endmodule : ius_chk

// ### testbench/ius_dev_model.sv
// device partner model: presents status bytes to the checker over the
// interlocked status-in / service-out handshake.
// assumes the checker raises service_out to take a byte and drops it after
// status_in falls; bytes are chosen by the bench or by evt_status.
`timescale 1ns/100ps
module ius_dev_model (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       arst_n,
    // handshake toward the checker
    input  wire logic       service_out,
    output logic [7:0]      bus_in,
    output logic            bus_in_par,
    output logic            status_in
);
    // status forms the device uses to report events
    function automatic logic [7:0] evt_status(input int k);
        case (k)
            0:       return 8'h80; // exception at selection, nothing done
            1:       return 8'hB0; // exception after accept rides with ending bits
            2:       return 8'h81; // exception after device end cleared
            3:       return 8'hA1; // not-ready to ready transition
            default: return 8'h40; // unexecutable command, lone
        endcase
    endfunction : evt_status

    // sense kept: byte 0 always, up to 31 more
    // a one-byte mux device sends what fits its 32 us timeout
    localparam int SENSE_MAX = 32;
    // may the device drop or replace its sense now
    function automatic logic sense_drop(input logic sensed, input logic plain_cmd,
                                        input logic other_dev, input logic par_uc);
        return sensed || plain_cmd || other_dev || par_uc;
    endfunction : sense_drop

    // idle lines at time zero
    initial
    begin
        bus_in     = 8'h00;
        bus_in_par = 1'b1;
        status_in  = 1'b0;
    end

    // one interlocked byte; ok stays low if the checker never answers
    task automatic send(input logic [7:0] b, input logic bad, output logic ok);
        int n;
        n = 0;
        @(posedge mclk);
        bus_in     <= b;
        bus_in_par <= ~^b ^ bad; // odd parity, broken on request
        status_in  <= 1'b1;
        // byte held until the acknowledge is seen at an edge
        while (service_out !== 1'b1 && n < 40)
        begin
            @(posedge mclk);
            n++;
        end
        ok = (service_out === 1'b1) && arst_n;
        // released lines must not keep the byte, so show its inverse
        status_in  <= 1'b0;
        bus_in     <= ~b;
        bus_in_par <= ~bus_in_par;
        while (service_out !== 1'b0 && n < 80)
        begin
            @(posedge mclk);
            n++;
        end
        ok = ok && (service_out === 1'b0);
    endtask : send
endmodule : ius_dev_model

// ### testbench/testbench.sv
// self-checking bench for the channel-side status checker
// assumes the design files and the device partner model are compiled first
`timescale 1ns/100ps
module testbench;
    // clock, reset and apb
    logic        mclk;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    // device pins and channel outputs
    logic [7:0]  bus_in;
    logic        bus_in_par;
    logic        status_in;
    logic        service_out;
    logic        chain_suppress;
    logic        status_taken;
    // bookkeeping
    int          fails;
    int          tests_run;
    int          nbytes;
    int          ntaken;
    logic [31:0] rd;
    logic        er;
    // context words: check enable, sequence, flags
    localparam logic [31:0] SB = 32'h0000_4000;
    localparam logic [31:0] IS = 32'h0000_4100;
    localparam logic [31:0] CU = 32'h0000_4200;
    localparam logic [31:0] TI = 32'h0000_0400;
    localparam logic [31:0] CH = 32'h0000_0800;
    localparam logic [31:0] RT = 32'h0000_1000;
    localparam logic [31:0] DY = 32'h0000_2000;

    // 40 MHz clock
    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;

    ius_chk ius_chk_i (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus_in(bus_in), .bus_in_par(bus_in_par),
        .status_in(status_in), .service_out(service_out),
        .chain_suppress(chain_suppress), .status_taken(status_taken));

    ius_dev_model ius_dev_model_i (.mclk(mclk), .arst_n(arst_n), .service_out(service_out),
        .bus_in(bus_in), .bus_in_par(bus_in_par), .status_in(status_in));

    // count taken pulses; each must match one byte sent
    always @(posedge mclk)
        if (status_taken === 1'b1)
            ntaken <= ntaken + 1;

    // verdict and end of run
    task finish_test;
        if (fails == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    // single comparison point
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one apb transfer; held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] d, output logic e);
        int n;
        n = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        d = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            fails++;
            finish_test;
        end
    endtask : apb

    // program context, present one byte, read back the verdict
    task automatic run(input logic [31:0] c, input logic [7:0] b, input logic bad,
                       input logic ei);
        logic ok;
        logic sup;
        logic [31:0] s;
        logic e;
        sup = b[7] | ei | bad; // exception, flagged byte or bad parity stops chaining
        apb(1'b1, 8'h00, c, s, e);
        apb(1'b1, 8'h04, 32'h0000_0500, s, e);
        ius_dev_model_i.send(b, bad, ok);
        nbytes++;
        chk("handshake", 32'(ok), 32'h1);
        if (ok !== 1'b1)
            finish_test;
        apb(1'b0, 8'h04, 32'h0, s, e);
        chk("stat_byte", 32'(s[7:0]), 32'(b));
        chk("inappropriate", 32'(s[8]), 32'(ei));
        chk("stat_suppress", 32'(s[9]), 32'(sup));
        chk("chain_suppress", 32'(chain_suppress), 32'(sup));
        chk("parity_err", 32'(s[10]), 32'(bad));
    endtask : run

    // main sequence
    initial
    begin
        fails = 0;
        tests_run = 0;
        nbytes = 0;
        ntaken = 0;
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        // reset values and an unmapped place
        apb(1'b0, 8'h00, 32'h0, rd, er);
        chk("ctrl_reset", rd, 32'h0000_4000);
        apb(1'b0, 8'h04, 32'h0, rd, er);
        chk("stat_reset", rd, 32'h0);
        apb(1'b0, 8'h0C, 32'h0, rd, er);
        chk("unmapped_err", 32'(er), 32'h1);
        chk("unmapped_rd", rd, 32'h0);
        // short busy
        run(SB, 8'h0A, 1'b0, 1'b0);
        run(SB, 8'h0E, 1'b0, 1'b0);
        run(SB, 8'h08, 1'b0, 1'b0);
        run(SB, 8'h0C, 1'b0, 1'b1);
        run(SB, 8'h88, 1'b0, 1'b1);
        run(SB, 8'h04, 1'b0, 1'b1);
        // unchained initial selection
        run(IS, 8'h20, 1'b0, 1'b1);
        run(IS, 8'h30, 1'b0, 1'b0);
        run(IS, 8'h05, 1'b0, 1'b1);
        run(IS, 8'h02, 1'b0, 1'b1);
        run(IS, 8'h44, 1'b0, 1'b1);
        run(IS, 8'hC4, 1'b0, 1'b1);
        run(IS | TI, 8'h20, 1'b0, 1'b0);
        run(IS, 8'h08, 1'b0, 1'b0);
        // chained initial selection, then one unchained byte with checking off
        run(IS | CH, 8'h08, 1'b0, 1'b1);
        run(IS | CH, 8'h18, 1'b0, 1'b1);
        run(IS | CH, 8'h28, 1'b0, 1'b0);
        run(IS | CH, 8'h09, 1'b0, 1'b0);
        run(IS | CH, 8'h42, 1'b0, 1'b1);
        run(IS | CH, 8'h82, 1'b0, 1'b1);
        run(IS | CH, 8'h20, 1'b0, 1'b1);
        run(32'h0000_0100, 8'h20, 1'b0, 1'b0);
        // device event forms, fresh device
        for (int k = 0; k < 5; k++)
            run(((k == 2 || k == 3) ? CU : IS) | 32'h20,
                ius_dev_model_i.evt_status(k), 1'b0, 1'b0);
        // history after a zero initial status, kept per device
        run(IS | 32'h05, 8'h00, 1'b0, 1'b0);
        apb(1'b0, 8'h04, 32'h0, rd, er);
        chk("history", 32'(rd[13:12]), 32'h1);
        run(CU | 32'h06, 8'h20, 1'b0, 1'b0);
        run(CU | 32'h05, 8'h20, 1'b0, 1'b1);
        run(IS | 32'h07, 8'h00, 1'b0, 1'b0);
        run(CU | 32'h07, 8'h18, 1'b0, 1'b1);
        run(IS | 32'h08, 8'h00, 1'b0, 1'b0);
        run(CU | 32'h08, 8'h30, 1'b0, 1'b0);
        run(IS | 32'h0F, 8'h00, 1'b0, 1'b0);
        run(CU | DY | 32'h0F, 8'h04, 1'b0, 1'b0);
        // history after an ending with channel end only
        run(CU | CH | 32'h09, 8'h10, 1'b0, 1'b0);
        run(CU | 32'h09, 8'h20, 1'b0, 1'b0);
        run(CU | CH | 32'h0A, 8'h10, 1'b0, 1'b0);
        run(CU | 32'h0A, 8'h18, 1'b0, 1'b1);
        run(CU | CH | RT | 32'h0B, 8'h52, 1'b0, 1'b0);
        run(CU | 32'h0B, 8'h30, 1'b0, 1'b1);
        run(CU | 32'h0C, 8'h10, 1'b0, 1'b0);
        run(CU | 32'h0C, 8'h04, 1'b0, 1'b0);
        run(CU | 32'h0C, 8'h01, 1'b0, 1'b1);
        run(CU | CH | 32'h0D, 8'h10, 1'b0, 1'b0);
        run(CU | CH | DY | 32'h0D, 8'h04, 1'b0, 1'b0);
        run(CU | CH | 32'h0D, 8'h44, 1'b0, 1'b0);
        run(CU | CH | 32'h0E, 8'h10, 1'b0, 1'b0);
        run(CU | CH | 32'h0E, 8'h04, 1'b0, 1'b1);
        run(CU | CH | 32'h111, 8'h10, 1'b0, 1'b0);
        run(CU | 32'h111, 8'h30, 1'b0, 1'b1);
        // bad parity, then clear of the sticky flag
        run(IS | 32'h10, 8'h30, 1'b1, 1'b0);
        apb(1'b1, 8'h04, 32'h0000_0400, rd, er);
        apb(1'b0, 8'h04, 32'h0, rd, er);
        chk("parity_clear", 32'(rd[10]), 32'h0);
        // byte count is read-only
        apb(1'b1, 8'h08, 32'h0000_FFFF, rd, er);
        apb(1'b0, 8'h08, 32'h0, rd, er);
        chk("count", rd, 32'(nbytes));
        chk("taken", 32'(ntaken), 32'(nbytes));
        finish_test;
    end
endmodule : testbench
